// ===== hw/eeprs_pkg.sv
// constants, state codes and timing counts of the serial eeprom slave port
package eeprs_pkg;
    // system clock
    localparam int CLK_PERIOD_NS = 50;

    // input noise filter: pulses up to this width are swallowed
    localparam int GLITCH_NS = 100;
    localparam int GLITCH_CYC = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FILT_W = 2;

    // internal programming time, longest figure, rounded down
    localparam int PROG_TIME_US = 5000;
    localparam int PROG_CYC = (PROG_TIME_US * 1000) / CLK_PERIOD_NS;
    // power-up to ready, longest figure, rounded down
    localparam int PU_TIME_NS = 100000;
    localparam int PU_CYC = PU_TIME_NS / CLK_PERIOD_NS;
    localparam int TIMER_W = 17;

    // slave address layout
    localparam logic [3:0] TYPE_CODE = 4'hA;
    localparam int EMB_BITS = 1;
    localparam logic [2:0] CS_MASK = 3'h6;
    localparam int DIR_BIT = 0;

    // memory organisation
    localparam int ADDR_W = 8 + EMB_BITS;
    localparam int MEM_DEPTH = 1 << ADDR_W;
    localparam int PAGE_W = 4;
    localparam int PAGE_BYTES = 1 << PAGE_W;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [3:0] BYTE_BITS = 4'h8;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'h0,
        ST_DEV   = 4'h1,
        ST_WADDR = 4'h2,
        ST_WDATA = 4'h3,
        ST_RDATA = 4'h4,
        ST_RACK  = 4'h5,
        ST_ACK   = 4'h6,
        ST_SKIP  = 4'h7
    } eeprs_state_type;
endpackage

// ===== hw/eeprs_line_if.sv
// filtered bus line levels and events passed from the input filter to the core
`timescale 1ns/1ps
interface eeprs_line_if;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic sda_lvl;

    modport filt (
        output scl_rise,
        output scl_fall,
        output start,
        output stop,
        output sda_lvl
    );
    modport core (
        input scl_rise,
        input scl_fall,
        input start,
        input stop,
        input sda_lvl
    );
endinterface

// ===== hw/eeprs_line_filter.sv
// synchroniser, glitch filter and edge/condition decoder for the two bus lines
`timescale 1ns/1ps
module eeprs_line_filter
    import eeprs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    eeprs_line_if.filt line
);
    logic [1:0] raw;
    logic [1:0] sync1_q;
    logic [1:0] sync2_q;
    logic [1:0] filt_q;
    logic [1:0] prev_q;

    // bit 0 is the clock line, bit 1 the data line
    assign raw = {sda_in, scl_in};

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sync1_q <= 2'h3;
            sync2_q <= 2'h3;
        end else begin
            sync1_q <= raw;
            sync2_q <= sync1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // a new level is taken only after it held longer than the noise width,
    // which costs a few cycles of latency on both lines alike
    generate
        for (genvar i = 0; i < 2; i++) begin : g_filt
            logic [FILT_W-1:0] cnt_q;
            always_ff @(posedge clk_sys) begin
                if (!rst_n) begin
                    cnt_q <= '0;
                    filt_q[i] <= 1'b1;
                end else if (sync2_q[i] == filt_q[i]) begin
                    cnt_q <= '0;
                end else if (cnt_q == FILT_W'(GLITCH_CYC)) begin // R22
                    cnt_q <= '0;
                    filt_q[i] <= sync2_q[i];
                end else begin
                    cnt_q <= FILT_W'(cnt_q + 1'b1);
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            prev_q <= 2'h3;
            line.scl_rise <= 1'b0;
            line.scl_fall <= 1'b0;
            line.start <= 1'b0;
            line.stop <= 1'b0;
            line.sda_lvl <= 1'b1;
        end else begin
            prev_q <= filt_q;
            line.scl_rise <= filt_q[0] & ~prev_q[0];
            line.scl_fall <= ~filt_q[0] & prev_q[0];
            line.start <= filt_q[0] & prev_q[0] & prev_q[1] & ~filt_q[1]; // R08
            line.stop <= filt_q[0] & prev_q[0] & ~prev_q[1] & filt_q[1]; // R08
            line.sda_lvl <= filt_q[1];
        end
    end
endmodule

// ===== hw/eeprs_slave.sv
// two-wire slave port of a small serial eeprom with page buffer and write timer
//
// Contract
// R01: sample data on clock rise, change on fall
// R02: data line driven low only, open drain
// R03: write-protect high blocks writes; floating is low
// R04: floating chip-select pins compare as low
// R05: master makes clock, start and stop
// R06: master starts only on an idle bus
// R07: master keeps data stable while clock high
// R08: data fall/rise with clock high: start/stop
// R09: ignore bus traffic until a start
// R10: stop ends the command in progress
// R11: slave address type bits must be 1010
// R12: address lsb one reads, zero writes
// R13: upper middle bits match pins, lower address memory
// R14: acknowledge matching address on ninth pulse
// R15: acknowledge word address and each write byte; with write-protect latched high the code leaves data bytes unacknowledged
// R16: read eight bits, release ninth, continue on ack
// R17: master ends read with no-ack then stop
// R18: byte write: address, word, data, acks, stop
// R19: stop after acked data starts programming
// R20: while programming, stay released and deaf
// R21: ready after power-up delay; reset returns standby
// R22: filter glitches up to 100 ns
// R23: page write: sixteen bytes, low bits wrap
// R24: write-protect sampled before first data byte
// R25: read without word address uses pointer
// R26: sequential read wraps at end of memory
// R27: unmatched address: no ack, idle till start
// R28: partial write byte is discarded
`timescale 1ns/1ps
module eeprs_slave
    import eeprs_pkg::*;
#(
    parameter int PROG_CYCLES = PROG_CYC
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [2:0] chip_select_pins,
    input wire logic write_protect,
    output logic prog_busy,
    output logic dev_ready
);
    eeprs_line_if ln();

    eeprs_line_filter u_filter (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .line(ln)
    );

    eeprs_state_type state_q;
    eeprs_state_type state_d;
    eeprs_state_type after_q;
    eeprs_state_type after_d;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic [7:0] shreg_q;
    logic [ADDR_W-1:0] ptr_q;
    logic [EMB_BITS-1:0] emb_q;
    logic [7:0] page_q [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] mask_q;
    logic [7:0] mem_q [MEM_DEPTH];
    logic pend_q;
    logic wp_q;
    logic busy_q;
    logic ready_q;
    logic [TIMER_W-1:0] timer_q;
    logic [TIMER_W-1:0] pu_q;
    logic sda_oe_q;
    logic sda_oe_d;
    logic sda_out_q;
    logic [3:0] pin_s1_q;
    logic [3:0] pin_s2_q;

    // strobes from the sequencer
    logic shift_in;
    logic tx_shift;
    logic take_dev;
    logic set_ptr;
    logic store;
    logic load;
    logic latch_wp;
    logic drop;
    logic prog_go;

    ////////////////////////////////////////////////////////////////////////
    // decoding
    wire logic [2:0] cs_pins = pin_s2_q[2:0];
    wire logic wp_pin = pin_s2_q[3];
    wire logic accept = ready_q & ~busy_q; // R20 R21
    wire logic byte_done = ln.scl_fall && (cnt_q == BYTE_BITS);
    wire logic type_ok = (shreg_q[7:4] == TYPE_CODE); // R11
    wire logic cs_ok = ((shreg_q[3:1] ^ cs_pins) & CS_MASK) == 3'h0; // R04 R13
    wire logic dev_match = type_ok & cs_ok;
    wire logic dir_read = shreg_q[DIR_BIT]; // R12
    wire logic [7:0] rd_byte = mem_q[ptr_q];
    wire logic [PAGE_W-1:0] slot = ptr_q[PAGE_W-1:0];
    wire logic [ADDR_W-PAGE_W-1:0] page_base = ptr_q[ADDR_W-1:PAGE_W];

    ////////////////////////////////////////////////////////////////////////
    // pins from outside pass two flip-flops; the pads pull these low when
    // undriven, so a floating pin is simply seen as a zero here
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pin_s1_q <= 4'h0;
            pin_s2_q <= 4'h0;
        end else begin
            pin_s1_q <= {write_protect, chip_select_pins}; // R03 R04
            pin_s2_q <= pin_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // byte sequencer
    always_comb begin
        state_d = state_q;
        after_d = after_q;
        cnt_d = cnt_q;
        sda_oe_d = sda_oe_q;
        shift_in = 1'b0;
        tx_shift = 1'b0;
        take_dev = 1'b0;
        set_ptr = 1'b0;
        store = 1'b0;
        load = 1'b0;
        latch_wp = 1'b0;
        drop = 1'b0;
        prog_go = 1'b0;
        if (!accept) begin
            // deaf and released while programming or powering up
            state_d = ST_IDLE; // R20
            sda_oe_d = 1'b0; // R20
        end else if (ln.stop) begin
            state_d = ST_IDLE; // R10
            sda_oe_d = 1'b0;
            prog_go = pend_q; // R19 R23
        end else if (ln.start) begin
            state_d = ST_DEV; // R09
            cnt_d = 4'h0;
            sda_oe_d = 1'b0;
            drop = 1'b1; // R28
        end else begin
            case (state_q)
                ST_IDLE: begin
                    state_d = ST_IDLE; // R09
                end
                ST_SKIP: begin
                    state_d = ST_SKIP; // R27
                end
                ST_DEV, ST_WADDR, ST_WDATA: begin
                    if (ln.scl_rise) begin
                        shift_in = 1'b1; // R01
                        cnt_d = 4'(cnt_q + 4'h1);
                    end else if (byte_done) begin
                        if (state_q == ST_DEV) begin
                            if (dev_match) begin
                                sda_oe_d = 1'b1; // R14
                                take_dev = 1'b1;
                                state_d = ST_ACK;
                                after_d = dir_read ? ST_RDATA : ST_WADDR; // R12 R25
                            end else begin
                                state_d = ST_SKIP; // R27
                            end
                        end else if (state_q == ST_WADDR) begin
                            set_ptr = 1'b1; // R18
                            sda_oe_d = 1'b1; // R15
                            state_d = ST_ACK;
                            after_d = ST_WDATA;
                        end else if (wp_q) begin
                            state_d = ST_SKIP; // R24
                            drop = 1'b1; // R03
                        end else begin
                            store = 1'b1; // R18
                            sda_oe_d = 1'b1; // R15
                            state_d = ST_ACK;
                            after_d = ST_WDATA;
                        end
                    end
                end
                ST_ACK: begin
                    if (ln.scl_fall) begin
                        cnt_d = 4'h0;
                        state_d = after_q;
                        latch_wp = (after_q == ST_WDATA) && (mask_q == '0); // R24
                        if (after_q == ST_RDATA) begin
                            load = 1'b1; // R25
                            sda_oe_d = ~rd_byte[7]; // R01 R02
                        end else begin
                            sda_oe_d = 1'b0;
                        end
                    end
                end
                ST_RDATA: begin
                    if (ln.scl_rise) begin
                        cnt_d = 4'(cnt_q + 4'h1);
                    end else if (byte_done) begin
                        sda_oe_d = 1'b0; // R16
                        state_d = ST_RACK;
                    end else if (ln.scl_fall) begin
                        tx_shift = 1'b1; // R01
                        sda_oe_d = ~shreg_q[6]; // R02
                    end
                end
                ST_RACK: begin
                    if (ln.scl_rise && ln.sda_lvl) begin
                        state_d = ST_SKIP; // R16 R17
                    end else if (ln.scl_fall) begin
                        load = 1'b1; // R16
                        sda_oe_d = ~rd_byte[7]; // R02
                        cnt_d = 4'h0;
                        state_d = ST_RDATA;
                    end
                end
                default: begin
                    state_d = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_q <= ST_IDLE; // R21
            after_q <= ST_IDLE;
            cnt_q <= 4'h0;
            sda_oe_q <= 1'b0;
            sda_out_q <= 1'b0;
        end else begin
            state_q <= state_d;
            after_q <= after_d;
            cnt_q <= cnt_d;
            sda_oe_q <= sda_oe_d; // R02
            sda_out_q <= 1'b0; // R02
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // shifter and address pointer
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            shreg_q <= 8'h00;
        end else if (load) begin
            shreg_q <= rd_byte;
        end else if (shift_in) begin
            shreg_q <= {shreg_q[6:0], ln.sda_lvl}; // R01
        end else if (tx_shift) begin
            shreg_q <= {shreg_q[6:0], 1'b0};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            emb_q <= '0;
        end else if (take_dev) begin
            emb_q <= shreg_q[EMB_BITS:1]; // R13
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ptr_q <= '0;
        end else if (set_ptr) begin
            ptr_q <= {emb_q, shreg_q}; // R13 R18
        end else if (load) begin
            ptr_q <= ADDR_W'(ptr_q + 1'b1); // R26
        end else if (store) begin
            ptr_q[PAGE_W-1:0] <= PAGE_W'(slot + 1'b1); // R23
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // page buffer: only fully received and acknowledged bytes enter it,
    // a repeated start throws away what a write had gathered so far
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            mask_q <= '0;
            pend_q <= 1'b0;
        end else if (drop || prog_go || ln.stop) begin
            mask_q <= '0; // R28
            pend_q <= 1'b0;
        end else if (store) begin
            mask_q[slot] <= 1'b1; // R23
            pend_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (store) begin
            page_q[slot] <= shreg_q; // R23
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wp_q <= 1'b0;
        end else if (latch_wp) begin
            wp_q <= wp_pin; // R24
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // the array is written in one go when programming starts; the timer
    // then only keeps the bus deaf, the stored data is already in place
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            for (int j = 0; j < MEM_DEPTH; j++) begin
                mem_q[j] <= ERASED_BYTE;
            end
        end else if (prog_go) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
                if (mask_q[i]) begin
                    mem_q[{page_base, PAGE_W'(i)}] <= page_q[i]; // R19 R23
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            busy_q <= 1'b0;
            timer_q <= '0;
        end else if (prog_go) begin
            busy_q <= 1'b1; // R19
            timer_q <= TIMER_W'(PROG_CYCLES - 1);
        end else if (busy_q) begin
            if (timer_q == '0) begin
                busy_q <= 1'b0; // R20
            end else begin
                timer_q <= TIMER_W'(timer_q - 1'b1);
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ready_q <= 1'b0; // R21
            pu_q <= '0;
        end else if (!ready_q) begin
            if (pu_q == TIMER_W'(PU_CYC - 1)) begin
                ready_q <= 1'b1; // R21
            end else begin
                pu_q <= TIMER_W'(pu_q + 1'b1);
            end
        end
    end

    assign sda_out = sda_out_q;
    assign sda_oe = sda_oe_q;
    assign prog_busy = busy_q;
    assign dev_ready = ready_q;
endmodule

// ===== sim/eeprs_mst.sv
// behavioural two-wire bus master that frames every transfer to the slave port
`timescale 1ns/1ps
module eeprs_mst
    import eeprs_pkg::*;
#(
    parameter int QTR = 15
) (
    input wire logic clk_sys,
    input wire logic sda_oe,
    input wire logic sda_out,
    output logic scl_pin,
    output logic sda_wire
);
    logic low_q = 1'b0;
    logic glitch_en = 1'b0;
    initial scl_pin = 1'b1;
    // wire has a pull-up: a released line reads high, never the last value
    assign sda_wire = (low_q || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;
    task automatic wait_q();
        repeat (QTR) @(posedge clk_sys);
    endtask
    // quarter-bit timing keeps each clock phase well beyond the input filter delay
    task automatic start();
        low_q <= 1'b0;
        wait_q();
        scl_pin <= 1'b1;
        wait_q();
        low_q <= 1'b1;
        wait_q();
        scl_pin <= 1'b0;
        wait_q();
    endtask
    task automatic stop();
        low_q <= 1'b1;
        wait_q();
        scl_pin <= 1'b1;
        wait_q();
        low_q <= 1'b0;
        wait_q();
    endtask
    // data moves only while the clock is low; an optional 50 ns dip tests the filter
    task automatic xfer(input logic b, output logic smp);
        low_q <= !b;
        wait_q();
        scl_pin <= 1'b1;
        wait_q();
        smp = sda_wire;
        if (glitch_en && b) begin
            low_q <= 1'b1;
            @(posedge clk_sys);
            low_q <= 1'b0;
        end
        wait_q();
        scl_pin <= 1'b0;
        wait_q();
    endtask
    task automatic put(input logic [7:0] data, input int nbits, output logic ack);
        logic smp;
        ack = 1'b0;
        for (int i = 7; i > 7 - nbits; i--) begin
            xfer(data[i], smp);
        end
        if (nbits == 8) begin
            xfer(1'b1, smp);
            ack = !smp;
        end
    endtask
    task automatic get(input logic ack, output logic [7:0] data);
        logic smp;
        for (int i = 7; i >= 0; i--) begin
            xfer(1'b1, smp);
            data[i] = smp;
        end
        xfer(!ack, smp);
    endtask
endmodule

// ===== sim/eeprs_slave_chk.sv
// concurrent checks on the slave port pins
`timescale 1ns/1ps
module eeprs_slave_chk
    import eeprs_pkg::*;
#(
    parameter int PROG_CYCLES = PROG_CYC
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic [2:0] chip_select_pins,
    input wire logic write_protect,
    input wire logic prog_busy,
    input wire logic dev_ready
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic [TIMER_W-1:0] busy_cnt_q;
    logic [TIMER_W-1:0] wait_cnt_q;
    always_ff @(posedge clk_sys) begin
        busy_cnt_q <= (rst_n && prog_busy) ? busy_cnt_q + 1'b1 : '0;
        wait_cnt_q <= (rst_n && !dev_ready) ? wait_cnt_q + 1'b1 : '0;
    end
    chk_drive_zero: assert property (sda_out == 1'b0) else $error("data output not zero");
    chk_edge_low: assert property ($changed(sda_oe) |-> !scl_in) else $error("data moved, clock high");
    chk_busy_quiet: assert property (prog_busy |-> !sda_oe) else $error("driven while programming");
    chk_ready_quiet: assert property (!dev_ready |-> !sda_oe) else $error("driven before ready");
    chk_busy_len: assert property ($fell(prog_busy) |-> busy_cnt_q == PROG_CYCLES) else $error("busy length");
    chk_busy_stop: assert property ($rose(prog_busy) |-> scl_in && sda_in && $past(scl_in, 4))
        else $error("programming began outside a stop");
    chk_ready_time: assert property ($rose(dev_ready) |-> wait_cnt_q >= PU_CYC - 2 && wait_cnt_q <= PU_CYC + 2)
        else $error("ready delay wrong");
    chk_ready_holds: assert property (dev_ready |=> dev_ready) else $error("ready dropped");
    chk_ack_release: assert property ($rose(sda_oe) |-> ##[1:1000] !sda_oe) else $error("line held");
    cover property ($rose(prog_busy));
    cover property ($rose(sda_oe));
    cover property ($rose(dev_ready));
endmodule
bind eeprs_slave eeprs_slave_chk #(.PROG_CYCLES(PROG_CYCLES)) eeprs_slave_chk_i (.clk_sys(clk_sys),
    .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .chip_select_pins(chip_select_pins), .write_protect(write_protect), .prog_busy(prog_busy),
    .dev_ready(dev_ready));

// ===== sim/tb_i2c_eeprom_slave_port.sv
// self-checking bench for the eeprom slave port
`timescale 1ns/1ps
module tb_i2c_eeprom_slave_port;
    import eeprs_pkg::*;
    localparam int PROG_T = 1000;
    localparam logic [2:0] CS_PINS = 3'h2;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic scl_pin;
    logic sda_wire;
    logic sda_out;
    logic sda_oe;
    logic [2:0] chip_select_pins = CS_PINS;
    logic write_protect = 1'b0;
    logic prog_busy;
    logic dev_ready;
    int failures = 0;
    int compares = 0;
    int cycles = 0;
    logic ack;
    logic [7:0] rd;
    logic [7:0] mem_exp [MEM_DEPTH];
    eeprs_slave #(.PROG_CYCLES(PROG_T)) eeprs_slave_i (.clk_sys(clk_sys), .rst_n(rst_n), .scl_in(scl_pin),
        .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe), .chip_select_pins(chip_select_pins),
        .write_protect(write_protect), .prog_busy(prog_busy), .dev_ready(dev_ready));
    eeprs_mst eeprs_mst_i (.clk_sys(clk_sys), .sda_oe(sda_oe), .sda_out(sda_out), .scl_pin(scl_pin),
        .sda_wire(sda_wire));
    initial begin
        forever #25 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 95000) begin
            failures++;
            close_out();
        end
    end
    task automatic close_out();
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] dev(input logic a8, input logic dir);
        return {TYPE_CODE, CS_PINS[2:1], a8, dir};
    endfunction
    task automatic put_ack(input logic [7:0] b, input logic exp);
        eeprs_mst_i.put(b, 8, ack);
        check(ack, exp);
    endtask
    task automatic set_ptr(input logic [8:0] a);
        eeprs_mst_i.start();
        put_ack(dev(a[8], 1'b0), 1'b1);
        put_ack(a[7:0], 1'b1);
    endtask
    task automatic read_at(input logic [8:0] a, input logic [7:0] exp);
        set_ptr(a);
        eeprs_mst_i.start();
        put_ack(dev(1'b0, 1'b1), 1'b1);
        eeprs_mst_i.get(1'b0, rd);
        check(rd, exp);
        eeprs_mst_i.stop();
    endtask
    task automatic wait_ready();
        for (int i = 0; i < 3000 && dev_ready !== 1'b1; i++) @(posedge clk_sys);
        check(dev_ready, 1'b1);
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 3000 && prog_busy !== 1'b0; i++) @(posedge clk_sys);
        check(prog_busy, 1'b0);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_power_up();
        repeat (16) @(posedge clk_sys);
        check({sda_oe, prog_busy, dev_ready}, 3'h0);
        rst_n <= 1'b1;
        eeprs_mst_i.start();
        put_ack(dev(1'b0, 1'b0), 1'b0);
        eeprs_mst_i.stop();
        wait_ready();
    endtask
    // a 50 ns dip while the clock is high must not read as start or stop
    task automatic t_byte_write();
        eeprs_mst_i.glitch_en = 1'b1;
        set_ptr(9'h1A3);
        put_ack(8'h5C, 1'b1);
        eeprs_mst_i.glitch_en = 1'b0;
        eeprs_mst_i.stop();
        check(prog_busy, 1'b1);
        eeprs_mst_i.start();
        put_ack(dev(1'b1, 1'b0), 1'b0);
        eeprs_mst_i.stop();
        wait_idle();
        read_at(9'h1A3, 8'h5C);
    endtask
    task automatic t_page_write();
        set_ptr(9'h00E);
        for (int i = 0; i < 17; i++) begin
            put_ack(8'h10 + 8'(i), 1'b1);
            mem_exp[(14 + i) % 16] = 8'h10 + 8'(i);
        end
        eeprs_mst_i.stop();
        wait_idle();
        set_ptr(9'h1FF);
        eeprs_mst_i.start();
        put_ack(dev(1'b0, 1'b1), 1'b1);
        for (int k = 0; k < 17; k++) begin
            eeprs_mst_i.get(k < 16, rd);
            check(rd, mem_exp[(511 + k) % 512]);
        end
        eeprs_mst_i.stop();
        eeprs_mst_i.start();
        put_ack(dev(1'b0, 1'b1), 1'b1);
        eeprs_mst_i.get(1'b0, rd);
        check(rd, mem_exp[16]);
        eeprs_mst_i.stop();
    endtask
    task automatic t_protect();
        write_protect <= 1'b1;
        set_ptr(9'h005);
        put_ack(8'hAA, 1'b0);
        eeprs_mst_i.stop();
        check(prog_busy, 1'b0);
        write_protect <= 1'b0;
        read_at(9'h005, mem_exp[5]);
    endtask
    task automatic t_no_match();
        logic [7:0] bad [2];
        bad[0] = {4'hB, CS_PINS[2:1], 2'b00};
        bad[1] = {TYPE_CODE, ~CS_PINS[2:1], 2'b00};
        for (int i = 0; i < 2; i++) begin
            eeprs_mst_i.start();
            put_ack(bad[i], 1'b0);
            put_ack(8'h00, 1'b0);
            eeprs_mst_i.stop();
        end
        // only the two upper pins take part in the compare, the lowest one is memory address
        chip_select_pins <= 3'h5;
        eeprs_mst_i.start();
        put_ack(dev(1'b0, 1'b0), 1'b0);
        eeprs_mst_i.stop();
        chip_select_pins <= 3'h3;
        eeprs_mst_i.start();
        put_ack(dev(1'b0, 1'b0), 1'b1);
        eeprs_mst_i.stop();
        chip_select_pins <= CS_PINS;
    endtask
    task automatic t_partial();
        set_ptr(9'h020);
        eeprs_mst_i.put(8'h99, 4, ack);
        eeprs_mst_i.stop();
        check(prog_busy, 1'b0);
        read_at(9'h020, ERASED_BYTE);
    endtask
    // reset in the middle of programming must drop back to standby
    task automatic t_rereset();
        set_ptr(9'h030);
        put_ack(8'h42, 1'b1);
        eeprs_mst_i.stop();
        rst_n <= 1'b0;
        repeat (4) @(posedge clk_sys);
        check({sda_oe, prog_busy, dev_ready}, 3'h0);
        rst_n <= 1'b1;
        wait_ready();
        read_at(9'h000, ERASED_BYTE);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        for (int i = 0; i < MEM_DEPTH; i++) mem_exp[i] = ERASED_BYTE;
        t_power_up();
        t_byte_write();
        t_page_write();
        t_protect();
        t_no_match();
        t_partial();
        t_rereset();
        close_out();
    end
endmodule
